// >>> design/bpmc_mode_ctrl.v
// Mode and switching control for a current-mode step-down regulator
`timescale 1ns/100ps
`include "bpmc_consts.vh"

// Notes on behaviour
// - Oscillator clock sets switch flip-flop
// - Ramp-sum comparator resets switch flip-flop
// - Reset dominates set; skip pulses
// - Support on-pulses down to 95 ns
// - Full PWM enables every fault detector
// - PFM entry after 2048 qualified cycles
// - PFM coasts while feedback above threshold
// - Feedback low: wake, wait 2.5 us, switch on
// - PFM pulse ends on peak or max on-time
// - Off delay, then pulse again or coast
// - PFM faults force reduced-current PWM
// - Thermal monitor off only in PFM
// - Full or half current limit in PWM
// - Reduced PWM re-enables all protection
// - Bootstrap absent/shorted flags over/under voltage
// - Bootstrap regulator current limited
// - Mode select high PWM, low PFM
// - Mode select ignored while asleep
// - Sleep waits 103 us before shutdown
module bpmc_mode_ctrl (
	// Clock, reset, enable
	input  wire       CORE_CLK,
	input  wire       RST,
	input  wire       CLK_EN,
	// Oscillator tick, one pulse per switching period
	input  wire       OSC_TICK,
	// Analog comparator outputs
	input  wire       RAMP_GT_EA,
	input  wire       FB_BELOW_REF,
	input  wire       PFM_PEAK_HIT,
	input  wire       SS_ABOVE_PFM_EN,
	// Fault detector outputs
	input  wire       DIODE_MISSING,
	input  wire       BOOT_OPEN,
	input  wire       BOOT_SHORT,
	input  wire       VOUT_SHORT,
	input  wire       SW_SHORT,
	// External control pins
	input  wire       MODE_SELECT,
	input  wire       SLEEP_BAR,
	input  wire       POWER_GOOD_N,
	// Switch and status outputs
	output reg        HS_ON,
	output reg  [1:0] ILIM_SEL,
	output reg        FAULT_DET_EN,
	output reg        THERMAL_MON_EN,
	output reg        BOOT_REG_ILIM_EN,
	output reg        BOOT_OV_FLAG,
	output reg        BOOT_UV_FLAG,
	output reg        SHUTDOWN,
	output reg        LOW_QUIESCENT_PFM
);

	localparam [5:0] ST_PWM     = 6'h01;
	localparam [5:0] ST_COAST   = 6'h02;
	localparam [5:0] ST_WAKE    = 6'h04;
	localparam [5:0] ST_PFM_ON  = 6'h08;
	localparam [5:0] ST_PFM_OFF = 6'h10;
	localparam [5:0] ST_RED_PWM = 6'h20;

	// Synchronised comparator, fault and pin levels
	wire [3:0]             cmp_s;
	wire [4:0]             flt_s;
	wire [1:0]             pin_s;
	wire                   asleep_q;
	reg  [5:0]             st_q;
	reg  [5:0]             st_d;
	reg  [`BPMC_CNT_W-1:0] ent_q;
	reg  [`BPMC_CNT_W-1:0] ent_d;
	reg  [`BPMC_CNT_W-1:0] tmr_q;
	reg  [`BPMC_CNT_W-1:0] tmr_d;
	reg                    sw_q;
	reg                    pfm_pulse;

	wire ramp_s     = cmp_s[0];
	wire fb_low_s   = cmp_s[1];
	wire peak_s     = cmp_s[2];
	wire ss_s       = cmp_s[3];
	wire diode_s    = flt_s[0];
	wire bopen_s    = flt_s[1];
	wire bshort_s   = flt_s[2];
	wire vout_s     = flt_s[3];
	wire swsh_s     = flt_s[4];
	wire mode_s     = pin_s[0];
	wire sleep_s    = pin_s[1];
	wire pfm_fault  = diode_s | bopen_s | bshort_s | vout_s | swsh_s;
	wire pfm_req    = sleep_s & ~mode_s;
	wire entry_ok   = pfm_req & ss_s & POWER_GOOD_N;
	wire in_coast   = (st_q == ST_COAST);
	wire in_wake    = (st_q == ST_WAKE);
	wire in_pfm_on  = (st_q == ST_PFM_ON);
	wire in_pfm_off = (st_q == ST_PFM_OFF);
	wire in_red     = (st_q == ST_RED_PWM);
	wire in_pfm     = in_coast | in_wake | in_pfm_on | in_pfm_off;
	wire pwm_state  = (st_q == ST_PWM) | in_red;

	// Comparator synchroniser
	bpmc_sync2 #(
		.W (4)
	) u_sync_cmp (
		.clk    (CORE_CLK),
		.rst    (RST),
		.en     (CLK_EN),
		.raw    ({SS_ABOVE_PFM_EN, PFM_PEAK_HIT, FB_BELOW_REF, RAMP_GT_EA}),
		.sync_q (cmp_s)
	);

	// Fault detector synchroniser
	bpmc_sync2 #(
		.W (5)
	) u_sync_flt (
		.clk    (CORE_CLK),
		.rst    (RST),
		.en     (CLK_EN),
		.raw    ({SW_SHORT, VOUT_SHORT, BOOT_SHORT, BOOT_OPEN, DIODE_MISSING}),
		.sync_q (flt_s)
	);

	// Mode and sleep pin synchroniser
	bpmc_sync2 #(
		.W (2)
	) u_sync_pin (
		.clk    (CORE_CLK),
		.rst    (RST),
		.en     (CLK_EN),
		.raw    ({SLEEP_BAR, MODE_SELECT}),
		.sync_q (pin_s)
	);

	// Sleep glitch filter
	bpmc_low_filt #(
		.W     (`BPMC_CNT_W),
		.LIMIT (`BPMC_SLEEP_CYC)
	) u_sleep_filt (
		.clk   (CORE_CLK),
		.rst   (RST),
		.en    (CLK_EN),
		.level (sleep_s),
		.low_q (asleep_q)
	);

	// Mode state machine
	always @* begin
		st_d  = st_q;
		ent_d = `BPMC_CNT_ZERO;
		tmr_d = tmr_q + `BPMC_CNT_ONE;
		case (st_q)
			ST_PWM: begin
				if (entry_ok) begin
					ent_d = ent_q + `BPMC_CNT_ONE;
					if (ent_q >= `BPMC_PFM_ENTRY_CYC - 1) begin
						st_d  = ST_COAST;
						ent_d = `BPMC_CNT_ZERO;
					end
				end
			end
			ST_COAST: begin
				tmr_d = `BPMC_CNT_ZERO;
				if (fb_low_s)
					st_d = ST_WAKE;
			end
			ST_WAKE: begin
				if (tmr_q >= `BPMC_WAKE_CYC - 1) begin
					st_d  = ST_PFM_ON;
					tmr_d = `BPMC_CNT_ZERO;
				end
			end
			ST_PFM_ON: begin
				if (peak_s || tmr_q >= `BPMC_PFM_MAX_ON_CYC - 1) begin
					st_d  = ST_PFM_OFF;
					tmr_d = `BPMC_CNT_ZERO;
				end
			end
			ST_PFM_OFF: begin
				if (tmr_q >= `BPMC_PFM_OFF_CYC - 1) begin
					st_d  = fb_low_s ? ST_PFM_ON : ST_COAST;
					tmr_d = `BPMC_CNT_ZERO;
				end
			end
			ST_RED_PWM: begin
				tmr_d = `BPMC_CNT_ZERO;
			end
			default: begin
				st_d  = ST_PWM;
				tmr_d = `BPMC_CNT_ZERO;
			end
		endcase
		if (in_pfm && pfm_fault) begin
			st_d  = ST_RED_PWM;
			tmr_d = `BPMC_CNT_ZERO;
		end
		if (in_pfm && !pfm_req) begin
			st_d  = ST_PWM;
			tmr_d = `BPMC_CNT_ZERO;
		end
		if (st_q == ST_RED_PWM && !pfm_req)
			st_d = ST_PWM;
		if (asleep_q) begin
			st_d  = ST_PWM;
			ent_d = `BPMC_CNT_ZERO;
			tmr_d = `BPMC_CNT_ZERO;
		end
	end

	always @(posedge CORE_CLK) begin
		if (RST) begin
			st_q  <= ST_PWM;
			ent_q <= `BPMC_CNT_ZERO;
			tmr_q <= `BPMC_CNT_ZERO;
		end else if (CLK_EN) begin
			st_q  <= st_d;
			ent_q <= ent_d;
			tmr_q <= tmr_d;
		end
	end

	// Switch flip-flop, reset dominant, no minimum blanking beyond one cycle
	always @(posedge CORE_CLK) begin
		if (RST) begin
			sw_q <= 1'b0;
		end else if (CLK_EN) begin
			if (!pwm_state || asleep_q || ramp_s) begin
				sw_q <= 1'b0;
			end else if (OSC_TICK) begin
				sw_q <= 1'b1;
			end
		end
	end

	always @* begin
		pfm_pulse = (st_q == ST_PFM_ON) & ~asleep_q;
	end

	// Switch drive and mode status
	always @(posedge CORE_CLK) begin
		if (RST) begin
			HS_ON    <= 1'b0;
			SHUTDOWN <= 1'b1;
			LOW_QUIESCENT_PFM   <= 1'b0;
		end else if (CLK_EN) begin
			HS_ON    <= sw_q | pfm_pulse;
			SHUTDOWN <= asleep_q;
			LOW_QUIESCENT_PFM   <= in_pfm;
		end
	end

	// Current limit level
	always @(posedge CORE_CLK) begin
		if (RST) begin
			ILIM_SEL <= `BPMC_ILIM_OFF;
		end else if (CLK_EN) begin
			if (asleep_q)
				ILIM_SEL <= `BPMC_ILIM_OFF;
			else if (in_red)
				ILIM_SEL <= `BPMC_ILIM_HALF;
			else
				ILIM_SEL <= `BPMC_ILIM_FULL;
		end
	end

	// Protection enables and bootstrap flags
	always @(posedge CORE_CLK) begin
		if (RST) begin
			FAULT_DET_EN     <= 1'b1;
			THERMAL_MON_EN   <= 1'b1;
			BOOT_REG_ILIM_EN <= 1'b1;
			BOOT_OV_FLAG     <= 1'b0;
			BOOT_UV_FLAG     <= 1'b0;
		end else if (CLK_EN) begin
			FAULT_DET_EN     <= pwm_state;
			THERMAL_MON_EN   <= ~in_pfm;
			BOOT_REG_ILIM_EN <= 1'b1;
			BOOT_OV_FLAG     <= bopen_s;
			BOOT_UV_FLAG     <= bshort_s;
		end
	end

endmodule // bpmc_mode_ctrl

// Two-flop synchroniser for a bundle of level inputs
module bpmc_sync2 #(
	parameter W = 1
) (
	// Clock, reset, enable
	input  wire         clk,
	input  wire         rst,
	input  wire         en,
	// Raw and synchronised levels
	input  wire [W-1:0] raw,
	output reg  [W-1:0] sync_q
);

	reg [W-1:0] meta_q;

	always @(posedge clk) begin
		if (rst) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else if (en) begin
			meta_q <= raw;
			sync_q <= meta_q;
		end
	end

endmodule // bpmc_sync2

// Low-level filter: output rises after the input stays low LIMIT cycles
module bpmc_low_filt #(
	parameter W     = 16,
	parameter LIMIT = 2
) (
	// Clock, reset, enable
	input  wire clk,
	input  wire rst,
	input  wire en,
	// Level to filter and filtered result
	input  wire level,
	output reg  low_q
);

	reg [W-1:0] cnt_q;

	always @(posedge clk) begin
		if (rst) begin
			cnt_q <= {W{1'b0}};
			low_q <= 1'b1;
		end else if (en) begin
			if (level) begin
				cnt_q <= {W{1'b0}};
				low_q <= 1'b0;
			end else if (cnt_q >= LIMIT - 1) begin
				low_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // bpmc_low_filt

// >>> pkg/bpmc_consts.vh
// Constants for the buck PWM/PFM mode controller
`ifndef BPMC_CONSTS_VH
`define BPMC_CONSTS_VH
// Clock period in picoseconds (250 MHz)
`define BPMC_CLK_PS           4000
// Minimum controllable on-pulse, ns
`define BPMC_MIN_ON_NS        95
`define BPMC_MIN_ON_CYC       ((`BPMC_MIN_ON_NS * 1000 + `BPMC_CLK_PS - 1) / `BPMC_CLK_PS)
// PFM entry qualification, in clock cycles
`define BPMC_PFM_ENTRY_CYC    2048
// PFM wake-up delay, ns
`define BPMC_WAKE_NS          2500
`define BPMC_WAKE_CYC         ((`BPMC_WAKE_NS * 1000) / `BPMC_CLK_PS)
// PFM maximum on-time and off delay, ns
`define BPMC_PFM_MAX_ON_NS    1000
`define BPMC_PFM_MAX_ON_CYC   ((`BPMC_PFM_MAX_ON_NS * 1000) / `BPMC_CLK_PS)
`define BPMC_PFM_OFF_NS       500
`define BPMC_PFM_OFF_CYC      ((`BPMC_PFM_OFF_NS * 1000 + `BPMC_CLK_PS - 1) / `BPMC_CLK_PS)
// Sleep filter, ns
`define BPMC_SLEEP_NS         103000
`define BPMC_SLEEP_CYC        ((`BPMC_SLEEP_NS * 1000) / `BPMC_CLK_PS)
// Counter width
`define BPMC_CNT_W            16
`define BPMC_CNT_ZERO         16'h0000
`define BPMC_CNT_ONE          16'h0001
// Current limit select codes
`define BPMC_ILIM_FULL        2'h3
`define BPMC_ILIM_HALF        2'h1
`define BPMC_ILIM_OFF         2'h0
`endif

// >>> dv/bpmc_sw_model.sv
// Behavioural power switch with ramp and peak comparators
`timescale 1ns/100ps
module bpmc_sw_model (
	input  wire logic       CORE_CLK, HS_ON, HOLD_HI,
	input  wire logic [7:0] ON_LEN,
	output logic            RAMP_GT_EA, PFM_PEAK_HIT
);
	logic [7:0] cnt_q;
	always @(posedge CORE_CLK)
		cnt_q <= HS_ON ? cnt_q + 8'h01 : 8'h00;
	assign RAMP_GT_EA   = HOLD_HI || (HS_ON && cnt_q >= ON_LEN);
	assign PFM_PEAK_HIT = HS_ON && cnt_q >= ON_LEN;
endmodule // bpmc_sw_model

// >>> dv/bpmc_chk.sv
// Assertion checker for the mode controller
`timescale 1ns/100ps
module bpmc_chk (
	input wire logic       CORE_CLK, RST, OSC_TICK, RAMP_GT_EA, BOOT_OPEN, VOUT_SHORT, SLEEP_BAR,
	input wire logic       HS_ON, LOW_QUIESCENT_PFM, SHUTDOWN, FAULT_DET_EN, THERMAL_MON_EN, BOOT_OV_FLAG,
	input wire logic [1:0] ILIM_SEL
);
	logic [15:0] on_q, slp_q;
	always @(posedge CORE_CLK) begin
		on_q  <= (RST || !(HS_ON && LOW_QUIESCENT_PFM)) ? 16'h0000 : on_q + 16'h0001;
		slp_q <= (RST || SLEEP_BAR) ? 16'h0000 : slp_q + 16'h0001;
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	sequence s_tick;
		(!RAMP_GT_EA && ILIM_SEL == 2'h3)[*3] ##0 OSC_TICK;
	endsequence
	property p_set; s_tick |-> ##3 HS_ON; endproperty
	property p_skip; (RAMP_GT_EA && !LOW_QUIESCENT_PFM)[*6] |-> !HS_ON; endproperty
	property p_boot; BOOT_OPEN[*4] |-> BOOT_OV_FLAG; endproperty
	property p_therm; LOW_QUIESCENT_PFM |-> !THERMAL_MON_EN; endproperty
	property p_lim; ILIM_SEL != 2'h0 && !LOW_QUIESCENT_PFM |-> FAULT_DET_EN && THERMAL_MON_EN; endproperty
	property p_flt; LOW_QUIESCENT_PFM && VOUT_SHORT |-> ##[1:6] ILIM_SEL == 2'h1; endproperty
	property p_maxon; on_q <= 16'h00fc; endproperty
	property p_sleep; $rose(SHUTDOWN) |-> slp_q >= 16'h6496; endproperty
	a_set: assert property (p_set) else $error("tick missed");
	a_skip: assert property (p_skip) else $error("switch kept on");
	a_boot: assert property (p_boot) else $error("no boot flag");
	a_therm: assert property (p_therm) else $error("thermal on");
	a_lim: assert property (p_lim) else $error("detector off");
	a_flt: assert property (p_flt) else $error("fault ignored");
	a_maxon: assert property (p_maxon) else $error("pulse too long");
	a_sleep: assert property (p_sleep) else $error("early shutdown");
endmodule // bpmc_chk
bind bpmc_mode_ctrl bpmc_chk u_chk (.*);

// >>> dv/bpmc_mode_ctrl_tb.sv
// Testbench for the buck mode controller
`timescale 1ns/100ps
module bpmc_mode_ctrl_tb;
	logic CORE_CLK = 0, RST = 1, OSC_TICK = 0, FB_BELOW_REF = 0, SS_ABOVE_PFM_EN = 0, MODE_SELECT = 1;
	logic SLEEP_BAR = 0, POWER_GOOD_N = 0, BOOT_OPEN = 0, BOOT_SHORT = 0, VOUT_SHORT = 0, HOLD_HI = 0;
	logic DIODE_MISSING = 0, SW_SHORT = 0;
	logic [7:0] ON_LEN = 8'h05;
	wire HS_ON, RAMP_GT_EA, PFM_PEAK_HIT, BOOT_OV_FLAG, BOOT_UV_FLAG, SHUTDOWN, LOW_QUIESCENT_PFM, FAULT_DET_EN;
	wire THERMAL_MON_EN, BOOT_REG_ILIM_EN;
	wire [1:0] ILIM_SEL;
	int err_total = 0, tests_run = 0, cyc_q = 0, n;
	always #2 CORE_CLK = ~CORE_CLK;
	bpmc_mode_ctrl DUT (.*, .CLK_EN(1'b1));
	bpmc_sw_model u_sw (.*);
	task chk(input logic [15:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(negedge CORE_CLK);
	endtask
	task hs_wait(input logic v, input int lim);
		for (n = 0; HS_ON !== v && n < lim; n++)
			cyc(1);
	endtask
	task final_report;
		$display("%0d errors in %0d checks", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge CORE_CLK)
		if (++cyc_q == 60000) begin
			err_total++;
			final_report;
		end
	task t_pwm;
		chk({HS_ON, ILIM_SEL, SHUTDOWN, BOOT_REG_ILIM_EN}, 16'h0003);
		SLEEP_BAR = 1;
		cyc(8);
		chk({SHUTDOWN, ILIM_SEL, FAULT_DET_EN, THERMAL_MON_EN}, 16'h000f);
		OSC_TICK = 1;
		cyc(1);
		OSC_TICK = 0;
		cyc(2);
		chk(HS_ON, 16'h0001);
		hs_wait(0, 20);
		chk(n > 5 && n < 15, 16'h0001);
		HOLD_HI = 1;
		cyc(3);
		OSC_TICK = 1;
		cyc(1);
		OSC_TICK = 0;
		cyc(6);
		chk(HS_ON, 16'h0000);
		HOLD_HI = 0;
		{BOOT_OPEN, BOOT_SHORT} = 2'h3;
		cyc(4);
		chk({BOOT_OV_FLAG, BOOT_UV_FLAG}, 16'h0003);
		{BOOT_OPEN, BOOT_SHORT} = 2'h0;
	endtask
	task t_pfm;
		{MODE_SELECT, SS_ABOVE_PFM_EN, POWER_GOOD_N} = 3'h3;
		cyc(1000);
		SS_ABOVE_PFM_EN = 0;
		cyc(1);
		SS_ABOVE_PFM_EN = 1;
		cyc(2040);
		chk(LOW_QUIESCENT_PFM, 16'h0000);
		cyc(640);
		chk({LOW_QUIESCENT_PFM, THERMAL_MON_EN, HS_ON}, 16'h0004);
		FB_BELOW_REF = 1;
		hs_wait(1, 700);
		chk(n > 620 && n < 640, 16'h0001);
		hs_wait(0, 300);
		chk(n < 20, 16'h0001);
		hs_wait(1, 300);
		chk(n > 120 && n < 135, 16'h0001);
		FB_BELOW_REF = 0;
		hs_wait(0, 300);
		hs_wait(1, 300);
		chk(HS_ON, 16'h0000);
		VOUT_SHORT = 1;
		cyc(8);
		chk({LOW_QUIESCENT_PFM, ILIM_SEL, FAULT_DET_EN, THERMAL_MON_EN}, 16'h0007);
	endtask
	task t_pfm_fault(input logic [1:0] sel);
		{VOUT_SHORT, MODE_SELECT} = 2'h1;
		cyc(8);
		MODE_SELECT = 0;
		cyc(2070);
		chk(LOW_QUIESCENT_PFM, 16'h0001);
		{SW_SHORT, DIODE_MISSING} = sel;
		cyc(8);
		chk({LOW_QUIESCENT_PFM, ILIM_SEL, FAULT_DET_EN, THERMAL_MON_EN}, 16'h0007);
		{SW_SHORT, DIODE_MISSING} = 2'h0;
	endtask
	task t_sleep;
		{VOUT_SHORT, MODE_SELECT, SLEEP_BAR} = 3'h2;
		cyc(25700);
		chk(SHUTDOWN, 16'h0000);
		cyc(100);
		chk({SHUTDOWN, ILIM_SEL, HS_ON}, 16'h0008);
	endtask
	initial begin
		cyc(3);
		RST = 0;
		cyc(1);
		t_pwm;
		t_pfm;
		t_pfm_fault(2'h1);
		t_pfm_fault(2'h2);
		t_sleep;
		final_report;
	end
endmodule // bpmc_mode_ctrl_tb
